// ===== inc/supervisor_pkg.sv
`default_nettype none
package supervisor_pkg;
    // Clock period in picoseconds (200 MHz)
    localparam longint CLK_PERIOD_PS = 5000;
    // Nominal watchdog timeout period, in milliseconds
    localparam longint WD_TIMEOUT_MS = 1600;
    // Nominal reset pulse width, in milliseconds
    localparam longint RESET_PULSE_MS = 200;
    // Minimum watchdog pulse width, in nanoseconds
    localparam longint WD_MIN_PULSE_NS = 50;
    // Longest time rounds down
    localparam longint WD_TIMEOUT_CYC = (WD_TIMEOUT_MS * 64'd1_000_000_000) / CLK_PERIOD_PS;
    // Least time rounds up
    localparam longint RESET_PULSE_CYC =
        (RESET_PULSE_MS * 64'd1_000_000_000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Least pulse width; shorter events are still taken
    localparam longint WD_MIN_PULSE_CYC =
        (WD_MIN_PULSE_NS * 64'd1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CNT_W = 32;
    // Three-level decode of the watchdog input
    typedef enum logic [1:0] {WD_LOW, WD_HIGH, WD_FLOAT} wd_level_e;
    typedef enum logic [1:0] {ST_RESET, ST_RUN, ST_BACKUP} sup_state_e;
    // Output levels after reset
    localparam logic RESET_N_INIT = 1'b0;
    localparam logic PF_FLAG_N_INIT = 1'b0;
endpackage
`default_nettype wire

// ===== core/wd_level_decode.sv
`default_nettype none
// Turns the two digital comparator outputs of the watchdog pad into a level and
// flags a service event whenever the level changes directly from one driven level to the other.
module wd_level_decode
    import supervisor_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_wd_above_hi,
    input wire logic i_wd_below_lo,
    output logic o_floating,
    output logic o_service
);
    wd_level_e level_ff, nxt_level;
    logic service_ff, nxt_service;

    always_comb
    begin
        if (i_wd_above_hi && !i_wd_below_lo)
            nxt_level = WD_HIGH;
        else if (i_wd_below_lo && !i_wd_above_hi)
            nxt_level = WD_LOW;
        else
            nxt_level = WD_FLOAT;
        // Any change between driven levels, even one cycle long
        nxt_service = (nxt_level != WD_FLOAT) && (level_ff != WD_FLOAT)
            && (nxt_level != level_ff);
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            level_ff <= WD_FLOAT;
            service_ff <= 1'b0;
        end
        else
        begin
            level_ff <= nxt_level;
            service_ff <= nxt_service;
        end
    end

    assign o_floating = (level_ff == WD_FLOAT);
    assign o_service = service_ff;
endmodule
`default_nettype wire

// ===== core/supervisor_reset_watchdog.sv
`default_nettype none
module supervisor_reset_watchdog
    import supervisor_pkg::*;
#(
    parameter logic [CNT_W-1:0] WD_TIMEOUT = CNT_W'(WD_TIMEOUT_CYC),
    parameter logic [CNT_W-1:0] RESET_PULSE = CNT_W'(RESET_PULSE_CYC)
)
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Main supply below reset threshold
    input wire logic i_supply_low,
    // Main supply more than hysteresis above backup level
    input wire logic i_supply_above_backup_hi,
    // Main supply more than hysteresis below backup level
    input wire logic i_supply_below_backup_lo,
    // Sense input below the power-fail reference
    input wire logic i_powerfail_sense_low,
    input wire logic i_wd_above_hi,
    input wire logic i_wd_below_lo,
    output logic o_reset_n,
    output logic o_reset,
    output logic o_powerfail_flag_n,
    // High while the switched output is fed from the backup supply
    output logic o_backup_selected
);

    // Sequencer state and its two counters
    sup_state_e state_ff, nxt_state;
    logic [CNT_W-1:0] pulse_cnt_ff, nxt_pulse_cnt;
    logic [CNT_W-1:0] wd_cnt_ff, nxt_wd_cnt;

    // Supply selection
    logic backup_ff, nxt_backup;

    // Registered pin levels
    logic reset_n_ff, nxt_reset_n;
    logic reset_ff, nxt_reset;
    logic pf_n_ff, nxt_pf_n;

    // Decoded watchdog pad
    logic wd_floating;
    logic wd_service;

    // Pad comparators arrive synchronous; decoding adds one cycle
    wd_level_decode u_wd_decode (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_wd_above_hi(i_wd_above_hi),
        .i_wd_below_lo(i_wd_below_lo),
        .o_floating(wd_floating),
        .o_service(wd_service)
    );

    // Supply switchover with hysteresis
    always_comb
    begin
        nxt_backup = backup_ff;
        if (!i_supply_low)
        begin
            nxt_backup = 1'b0;
        end
        else if (i_supply_below_backup_lo)
        begin
            nxt_backup = 1'b1;
        end
        else if (i_supply_above_backup_hi)
        begin
            nxt_backup = 1'b0;
        end
        // Between the two trip points the previous choice holds
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            backup_ff <= 1'b0;
        end
        else
        begin
            backup_ff <= nxt_backup;
        end
    end

    // Reset sequencer and watchdog timer
    always_comb
    begin
        nxt_state = state_ff;
        nxt_pulse_cnt = pulse_cnt_ff;
        nxt_wd_cnt = wd_cnt_ff;
        unique case (state_ff)
            ST_RESET:
            begin
                nxt_wd_cnt = '0;
                // A brownout inside the pulse starts the full width again
                if (i_supply_low)
                begin
                    nxt_pulse_cnt = '0;
                end
                else if (pulse_cnt_ff >= RESET_PULSE - 1'b1)
                begin
                    nxt_state = ST_RUN;
                    nxt_pulse_cnt = '0;
                end
                else
                begin
                    nxt_pulse_cnt = pulse_cnt_ff + 1'b1;
                end
            end

            ST_RUN:
            begin
                if (i_supply_low)
                begin
                    nxt_state = ST_RESET;
                    nxt_pulse_cnt = '0;
                    nxt_wd_cnt = '0;
                end
                else if (wd_floating || wd_service)
                begin
                    // A service or a floating pad keeps the timer at zero
                    nxt_wd_cnt = '0;
                end
                else if (wd_cnt_ff >= WD_TIMEOUT - 1'b1)
                begin
                    nxt_state = ST_RESET;
                    nxt_pulse_cnt = '0;
                    nxt_wd_cnt = '0;
                end
                else
                begin
                    nxt_wd_cnt = wd_cnt_ff + 1'b1;
                end
            end

            ST_BACKUP:
            begin
                nxt_wd_cnt = '0;
                nxt_pulse_cnt = '0;
            end
        endcase
        // Backup overrides whatever the case above chose
        if (backup_ff)
        begin
            nxt_state = ST_BACKUP;
            nxt_wd_cnt = '0;
            nxt_pulse_cnt = '0;
        end
        else if (state_ff == ST_BACKUP)
        begin
            // Leaving backup always goes through a full reset pulse
            nxt_state = ST_RESET;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            state_ff <= ST_RESET;
            pulse_cnt_ff <= '0;
            wd_cnt_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
            pulse_cnt_ff <= nxt_pulse_cnt;
            wd_cnt_ff <= nxt_wd_cnt;
        end
    end

    // Reset pins follow the next state, the flag follows sense and backup; each pin is a flip-flop
    always_comb
    begin
        nxt_reset_n = (nxt_state == ST_RUN);
        nxt_reset = !nxt_reset_n;
        // Low sense and backup mode both pull the flag low
        nxt_pf_n = !(i_powerfail_sense_low || backup_ff);
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            reset_n_ff <= RESET_N_INIT;
            reset_ff <= !RESET_N_INIT;
            pf_n_ff <= PF_FLAG_N_INIT;
        end
        else
        begin
            reset_n_ff <= nxt_reset_n;
            reset_ff <= nxt_reset;
            pf_n_ff <= nxt_pf_n;
        end
    end

    assign o_reset_n = reset_n_ff;
    assign o_reset = reset_ff;
    assign o_powerfail_flag_n = pf_n_ff;
    assign o_backup_selected = backup_ff;
endmodule
`default_nettype wire

// ===== verification/wd_host_model.sv
`default_nettype none
// Host side of the watchdog pad: toggles every 16 cycles, holds, or floats
module wd_host_model
(
    input wire logic i_clk,
    input wire logic i_toggle,
    input wire logic i_float,
    output logic o_above_hi,
    output logic o_below_lo
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_ff = 4'h0;
    logic lvl_ff = 1'b0;
    always_ff @(posedge i_clk)
    begin
        cnt_ff <= cnt_ff + 4'h1;
        if (i_toggle && cnt_ff == 4'h0) lvl_ff <= !lvl_ff;
    end
    assign o_above_hi = !i_float && lvl_ff;
    assign o_below_lo = !i_float && !lvl_ff;
endmodule
`default_nettype wire

// ===== verification/supervisor_properties.sv
`default_nettype none
module supervisor_properties
    import supervisor_pkg::*;
#(
    parameter logic [CNT_W-1:0] WD_TIMEOUT = 50,
    parameter logic [CNT_W-1:0] RESET_PULSE = 20
)
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_supply_low,
    input wire logic i_supply_above_backup_hi,
    input wire logic i_supply_below_backup_lo,
    input wire logic i_powerfail_sense_low,
    input wire logic i_wd_above_hi,
    input wire logic i_wd_below_lo,
    input wire logic o_reset_n,
    input wire logic o_reset,
    input wire logic o_powerfail_flag_n,
    input wire logic o_backup_selected
);
    logic [CNT_W-1:0] low_cnt_ff;
    logic [CNT_W-1:0] wd_cnt_ff;
    logic [1:0] pad_ff;
    logic steady;
    assign steady = (i_wd_above_hi ^ i_wd_below_lo) && pad_ff == {i_wd_above_hi, i_wd_below_lo};
    // Cycles reset has been low, and cycles the pad has held one driven level
    always_ff @(posedge i_clk)
    begin
        pad_ff <= {i_wd_above_hi, i_wd_below_lo};
        low_cnt_ff <= (!i_rst_n || o_reset_n) ? '0 : low_cnt_ff + 1;
        wd_cnt_ff <= (i_rst_n && o_reset_n && steady) ? wd_cnt_ff + 1 : '0;
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    sequence enter_backup;
        i_supply_low && i_supply_below_backup_lo;
    endsequence
    sequence hold_backup;
        o_backup_selected && i_supply_low && !i_supply_above_backup_hi;
    endsequence
    reset_inverse_a: assert property (o_reset == !o_reset_n)
        else $error("reset outputs not inverse");
    brownout_assert_a: assert property (i_supply_low |=> !o_reset_n)
        else $error("reset not asserted on low supply");
    pulse_width_a: assert property ($rose(o_reset_n) |-> low_cnt_ff >= RESET_PULSE)
        else $error("reset pulse too short");
    wd_timeout_a: assert property ($fell(o_reset_n) && !$past(i_supply_low) |-> wd_cnt_ff >= WD_TIMEOUT)
        else $error("watchdog reset too early");
    wd_late_a: assert property (wd_cnt_ff <= WD_TIMEOUT + 4)
        else $error("watchdog reset too late");
    pf_follow_a: assert property ($past(i_rst_n) && !o_backup_selected && !$past(o_backup_selected)
        && !$past(o_backup_selected, 2) |-> o_powerfail_flag_n == !$past(i_powerfail_sense_low))
        else $error("power-fail flag wrong");
    backup_forces_a: assert property (o_backup_selected |=> !o_powerfail_flag_n && !o_reset_n)
        else $error("backup outputs wrong");
    main_select_a: assert property (!i_supply_low |=> !o_backup_selected)
        else $error("backup with valid supply");
    backup_entry_a: assert property (enter_backup |=> o_backup_selected)
        else $error("backup not entered");
    backup_hold_a: assert property (hold_backup |=> o_backup_selected)
        else $error("backup left inside hysteresis");
endmodule
bind supervisor_reset_watchdog supervisor_properties #(.WD_TIMEOUT(WD_TIMEOUT),
    .RESET_PULSE(RESET_PULSE)) props (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_supply_low(i_supply_low), .i_supply_above_backup_hi(i_supply_above_backup_hi),
    .i_supply_below_backup_lo(i_supply_below_backup_lo),
    .i_powerfail_sense_low(i_powerfail_sense_low), .i_wd_above_hi(i_wd_above_hi),
    .i_wd_below_lo(i_wd_below_lo), .o_reset_n(o_reset_n), .o_reset(o_reset),
    .o_powerfail_flag_n(o_powerfail_flag_n), .o_backup_selected(o_backup_selected));
`default_nettype wire

// ===== verification/supervisor_reset_watchdog_test.sv
`default_nettype none
module supervisor_reset_watchdog_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 0, i_rst_n = 0, sup_low = 0, above_hi = 1, below_lo = 0, pf_low = 0;
    logic tog = 0, flt = 1, wd_hi, wd_lo, rst_n, rst, pf_n, bk;
    int n_fail = 0, samples_checked = 0, k;
    always #2.5 i_clk = !i_clk;
    wd_host_model host (.i_clk(i_clk), .i_toggle(tog), .i_float(flt), .o_above_hi(wd_hi),
        .o_below_lo(wd_lo));
    supervisor_reset_watchdog #(.WD_TIMEOUT(32'h0000_0032), .RESET_PULSE(32'h0000_0014)) dut (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_supply_low(sup_low),
        .i_supply_above_backup_hi(above_hi), .i_supply_below_backup_lo(below_lo),
        .i_powerfail_sense_low(pf_low), .i_wd_above_hi(wd_hi), .i_wd_below_lo(wd_lo),
        .o_reset_n(rst_n), .o_reset(rst), .o_powerfail_flag_n(pf_n), .o_backup_selected(bk));
    task report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    // Waits for the reset output to reach a level; k holds the cycles taken
    task wait_rst(input logic v, input int lim);
        k = 0;
        while (rst_n !== v && k < lim)
        begin
            @(posedge i_clk) #1;
            k++;
        end
        if (rst_n !== v)
        begin
            n_fail++;
            report_and_stop();
        end
        // Realign so the next stimulus lands on a rising edge
        @(posedge i_clk);
    endtask
    initial
    begin
        cyc(3);
        i_rst_n <= 1;
        wait_rst(1, 40);
        chk(k >= 20, 1);
        cyc(100);
        chk(rst_n, 1);
        flt <= 0;
        tog <= 1;
        cyc(300);
        chk(rst_n, 1);
        tog <= 0;
        wait_rst(0, 70);
        chk(rst, 1);
        wait_rst(1, 30);
        chk(k > 15, 1);
        wait_rst(0, 70);
        chk(k > 45, 1);
        wait_rst(1, 30);
        flt <= 1;
        sup_low <= 1;
        cyc(2);
        chk(rst_n, 0);
        sup_low <= 0;
        cyc(10);
        sup_low <= 1;
        cyc(1);
        sup_low <= 0;
        cyc(15);
        chk(rst_n, 0);
        wait_rst(1, 30);
        pf_low <= 1;
        cyc(2);
        chk(pf_n, 0);
        pf_low <= 0;
        cyc(2);
        chk(pf_n, 1);
        sup_low <= 1;
        above_hi <= 0;
        below_lo <= 1;
        cyc(3);
        chk({bk, pf_n, rst_n, rst}, 4'h9);
        below_lo <= 0;
        cyc(3);
        chk(bk, 1);
        sup_low <= 0;
        below_lo <= 1;
        cyc(2);
        chk(bk, 0);
        report_and_stop();
    end
endmodule
`default_nettype wire
